// *** inc/ssd_regs.svh ***
// Offsets, field positions, reset values and codes of the SPI system command decoder
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH

// ****************************************
// Command word fields
// ****************************************
`define SSD_BIT_DEV        15
`define SSD_BIT_RW         14
`define SSD_BIT_SYS        13
`define SSD_SUB_HI         12
`define SSD_SUB_LO         11
`define SSD_CH_HI          10
`define SSD_CH_LO          9
`define SSD_CODE_HI        8
`define SSD_CODE_LO        1
`define SSD_CMD_BITS       5'd16
`define SSD_WDATA_BITS     5'd16

// ****************************************
// Subsystems and command codes
// ****************************************
`define SSD_SUB_ADC        2'b00
`define SSD_SUB_DAC        2'b11
`define SSD_CODE_BURST     8'h05
`define SSD_CODE_WSTOP     8'h00
`define SSD_CODE_WSTART    8'h01
`define SSD_CODE_MIDSCALE  8'h02
`define SSD_CODE_RESTORE   8'h03
`define SSD_CODE_FLOAT     8'h04
`define SSD_CODE_SWEXIT    8'h05
`define SSD_REG_ADDR_MIN   8'h20

// ****************************************
// Register offsets and layout
// ****************************************
`define SSD_OFF_CTRL       8'h00
`define SSD_OFF_STATUS     8'h04
`define SSD_OFF_DAC        8'h08
`define SSD_OFF_RES_HI     3'b010
`define SSD_CTRL_MODE_LO   8
`define SSD_CTRL_CLOSE     10
`define SSD_MASK_RESET     8'h00
`define SSD_MIDSCALE       18'h00000

`endif

// *** inc/ssd_pkg.sv ***
// Types of the SPI system command decoder
`default_nettype none
package ssd_pkg;

	typedef enum logic [1:0] {
		SSD_PH_CMD   = 2'b00,
		SSD_PH_WDATA = 2'b01,
		SSD_PH_DONE  = 2'b11,
		SSD_PH_RESP  = 2'b10
	} ssd_phase_e;

	typedef enum logic {
		SSD_FLT_IDLE  = 1'b0,
		SSD_FLT_TRIP  = 1'b1
	} ssd_fault_e;

	typedef enum logic [1:0] {
		SSD_MODE_HIZ   = 2'b00,
		SSD_MODE_VOLTS = 2'b01,
		SSD_MODE_AMPS  = 2'b10
	} ssd_mode_e;

endpackage : ssd_pkg
`default_nettype wire

// *** logic/ssd_decoder.sv ***
// SPI system command decoder with AHB-Lite register access
// What this block does
// - Command word: bit15 address, bit14 read-high, bit13 system, sub, channel, code fields.
// - ADC burst read code 5 sends enabled channel results, channel 0 to 7.
// - DAC write code 0 with channel 0 stops the waveform generator.
// - DAC write code 1 starts the waveform generator.
// - DAC write code 2 sets the output code to mid-scale zero.
// - The mid-scale command also resets the slew state machine.
// - The mid-scale command is ignored while the waveform generator runs.
// - Code 3 clears output stickies, restores previous mode, refreshes DAC, idles.
// - Code 4 clears output stickies, sets high impedance mode, idles.
// - Codes 3 and 4 do nothing while the output fault machine idles.
// - Code 5 leaves the tripped input switch fault machine.
// - Code 5 clears switch stickies, frees limiter, closes switch; idle ignores it.
// - Field values 0x20 to 0xff are register reads and writes.
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ssd_regs.svh"

module ssd_decoder
	import ssd_pkg::*;
#(
	parameter int   WORD_W    = 24,
	parameter int   BUF_DEPTH = 2,
	parameter logic DEV_ADDR  = 1'b0
)(
	input  wire logic               CLK,
	input  wire logic               RST_N,
	input  wire logic               HSEL,
	input  wire logic [31:0]        HADDR,
	input  wire logic [1:0]         HTRANS,
	input  wire logic               HWRITE,
	input  wire logic [2:0]         HSIZE,
	input  wire logic [31:0]        HWDATA,
	input  wire logic               HREADY,
	output logic      [31:0]        HRDATA,
	output logic                    HREADYOUT,
	output logic                    HRESP,
	input  wire logic               SCLK,
	input  wire logic               CS_N,
	input  wire logic               MOSI,
	output logic                    MISO,
	output logic                    MISO_OE,
	input  wire logic               AO_SHORT_DET,
	input  wire logic               AO_OVLD_DET,
	input  wire logic               SW_SHORT_DET,
	input  wire logic               SW_OVLD_DET,
	input  wire logic [15:0]        REG_RDATA,
	output logic                    WAVE_RUN,
	output logic      [17:0]        DAC_CODE,
	output logic                    DAC_LOAD,
	output logic                    SLEW_RESET,
	output logic      [1:0]         DRIVE_MODE,
	output logic                    OUT_FAULT,
	output logic                    SW_FAULT,
	output logic                    SW_CLOSE,
	output logic                    SW_LIMIT,
	output logic                    REG_WR,
	output logic                    REG_RD,
	output logic      [1:0]         REG_SUB,
	output logic      [7:0]         REG_ADDR,
	output logic      [15:0]        REG_WDATA
);

	localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam int CNT_W = $clog2(BUF_DEPTH + 1);
	localparam int OC_W  = $clog2(WORD_W);

	function automatic logic [3:0] ssd_next_ch(input logic [7:0] m, input logic [3:0] from);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (m[i] && (4'(i) >= from))
				r = {1'b1, 3'(i)};
		end
		return r;
	endfunction : ssd_next_ch

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic sclk_s1, sclk_s2, sclk_s3, csn_s1, csn_s2, mosi_s1, mosi_s2;
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{csn_s1, csn_s2}            <= 2'h3;
			{mosi_s1, mosi_s2}          <= 2'h0;
		end else begin
			{sclk_s1, sclk_s2, sclk_s3} <= {SCLK, sclk_s1, sclk_s2};
			{csn_s1, csn_s2}            <= {CS_N, csn_s1};
			{mosi_s1, mosi_s2}          <= {MOSI, mosi_s1};
		end
	end
	wire sclk_rise = sclk_s2 & ~sclk_s3;
	wire sclk_fall = ~sclk_s2 & sclk_s3;
	wire frame_off = csn_s2;

	// ****************************************
	// Command receiver
	// ****************************************
	ssd_phase_e  phase_r;
	logic [4:0]  bit_cnt_r;
	logic [15:0] rx_sh_r, cmd_word_r, wdata_r;
	logic        cmd_valid_r, wdata_valid_r;
	wire  [15:0] rx_word   = {rx_sh_r[14:0], mosi_s2};
	wire         rx_reg_wr = (rx_word[`SSD_BIT_DEV] == DEV_ADDR) && !rx_word[`SSD_BIT_RW] && rx_word[`SSD_BIT_SYS]
		&& (rx_word[`SSD_CODE_HI:`SSD_CODE_LO] >= `SSD_REG_ADDR_MIN);

	always_ff @(posedge CLK) begin
		if (!RST_N || frame_off) begin
			phase_r       <= SSD_PH_CMD;
			bit_cnt_r     <= 5'h0;
			rx_sh_r       <= 16'h0;
			cmd_valid_r   <= 1'b0;
			wdata_valid_r <= 1'b0;
			if (!RST_N) begin
				cmd_word_r <= 16'h0;
				wdata_r    <= 16'h0;
			end
		end else begin
			cmd_valid_r   <= 1'b0;
			wdata_valid_r <= 1'b0;
			if (sclk_rise) begin
				rx_sh_r <= rx_word;
				unique case (phase_r)
					SSD_PH_CMD: begin
						if (bit_cnt_r == `SSD_CMD_BITS - 5'd1) begin
							bit_cnt_r   <= 5'h0;
							cmd_word_r  <= rx_word;
							cmd_valid_r <= 1'b1;
							phase_r     <= rx_reg_wr ? SSD_PH_WDATA : SSD_PH_RESP;
						end else
							bit_cnt_r <= bit_cnt_r + 5'd1;
					end
					SSD_PH_WDATA: begin
						if (bit_cnt_r == `SSD_WDATA_BITS - 5'd1) begin
							wdata_r       <= rx_word;
							wdata_valid_r <= 1'b1;
							phase_r       <= SSD_PH_DONE;
						end else
							bit_cnt_r <= bit_cnt_r + 5'd1;
					end
					SSD_PH_RESP: ;
					SSD_PH_DONE: ;
				endcase
			end
		end
	end

	// ****************************************
	// Command decode
	// ****************************************
	logic       wave_run_r;
	ssd_fault_e ao_st_r, sw_st_r;
	wire  [1:0] c_sub  = cmd_word_r[`SSD_SUB_HI:`SSD_SUB_LO];
	wire  [1:0] c_ch   = cmd_word_r[`SSD_CH_HI:`SSD_CH_LO];
	wire  [7:0] c_code = cmd_word_r[`SSD_CODE_HI:`SSD_CODE_LO];
	wire        c_rd   = cmd_word_r[`SSD_BIT_RW];
	wire        c_ok   = cmd_valid_r && (cmd_word_r[`SSD_BIT_DEV] == DEV_ADDR) && cmd_word_r[`SSD_BIT_SYS];
	wire        c_reg  = c_code >= `SSD_REG_ADDR_MIN;
	wire        c_dac  = c_ok && !c_rd && (c_sub == `SSD_SUB_DAC) && !c_reg;
	// Any code not matched below falls through with no effect
	wire do_stop    = c_dac && (c_code == `SSD_CODE_WSTOP) && (c_ch == 2'b00);
	wire do_start   = c_dac && (c_code == `SSD_CODE_WSTART);
	wire do_mid     = c_dac && (c_code == `SSD_CODE_MIDSCALE) && !wave_run_r;
	wire do_restore = c_dac && (c_code == `SSD_CODE_RESTORE) && (ao_st_r == SSD_FLT_TRIP);
	wire do_float   = c_dac && (c_code == `SSD_CODE_FLOAT) && (ao_st_r == SSD_FLT_TRIP);
	wire do_swexit  = c_dac && (c_code == `SSD_CODE_SWEXIT) && (sw_st_r == SSD_FLT_TRIP);
	wire do_burst   = c_ok && c_rd && (c_sub == `SSD_SUB_ADC) && (c_code == `SSD_CODE_BURST);
	wire do_reg_rd  = c_ok && c_rd && c_reg;

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	logic       ahb_wr_r;
	logic [7:0] ahb_addr_r;
	logic [7:0] mask_r;
	logic [WORD_W-1:0] result_r [8];
	wire ahb_sel = HSEL && HTRANS[1] && HREADY;
	wire wr_ctrl = ahb_wr_r && (ahb_addr_r == `SSD_OFF_CTRL);
	wire wr_dac  = ahb_wr_r && (ahb_addr_r == `SSD_OFF_DAC);
	wire wr_res  = ahb_wr_r && (ahb_addr_r[7:5] == `SSD_OFF_RES_HI) && (ahb_addr_r[1:0] == 2'b00);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ahb_wr_r   <= 1'b0;
			ahb_addr_r <= 8'h00;
			HREADYOUT  <= 1'b1;
			HRESP      <= 1'b0;
		end else begin
			ahb_wr_r <= ahb_sel && HWRITE;
			if (ahb_sel)
				ahb_addr_r <= HADDR[7:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mask_r <= `SSD_MASK_RESET;
			for (int i = 0; i < 8; i++)
				result_r[i] <= '0;
		end else begin
			if (wr_ctrl)
				mask_r <= HWDATA[7:0];
			if (wr_res)
				result_r[ahb_addr_r[4:2]] <= HWDATA[WORD_W-1:0];
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		if (HADDR[7:0] == `SSD_OFF_CTRL)
			rd_mux = {21'h0, SW_CLOSE, DRIVE_MODE, mask_r};
		else if (HADDR[7:0] == `SSD_OFF_STATUS)
			rd_mux = {22'h0, 2'b00, SW_LIMIT, OUT_FAULT, SW_FAULT, wave_run_r, 4'h0};
		else if (HADDR[7:0] == `SSD_OFF_DAC)
			rd_mux = {14'h0, DAC_CODE};
		else if ((HADDR[7:5] == `SSD_OFF_RES_HI) && (HADDR[1:0] == 2'b00))
			rd_mux = 32'(result_r[HADDR[4:2]]);
	end

	// ****************************************
	// Waveform, DAC and output fault state
	// ****************************************
	logic [1:0] prev_mode_r;
	logic       ao_short_r, ao_ovld_r, sw_short_r, sw_ovld_r;
	wire        ao_clr = do_restore || do_float;
	wire        ao_trip = AO_SHORT_DET || AO_OVLD_DET;
	wire        sw_trip = SW_SHORT_DET || SW_OVLD_DET;

	always_ff @(posedge CLK) begin
		if (!RST_N)
			wave_run_r <= 1'b0;
		else if (do_start)
			wave_run_r <= 1'b1;
		else if (do_stop)
			wave_run_r <= 1'b0;
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DAC_CODE   <= `SSD_MIDSCALE;
			DAC_LOAD   <= 1'b0;
			SLEW_RESET <= 1'b0;
		end else begin
			DAC_LOAD   <= do_mid || do_restore || wr_dac;
			SLEW_RESET <= do_mid;
			if (do_mid)
				DAC_CODE <= `SSD_MIDSCALE;
			else if (wr_dac)
				DAC_CODE <= HWDATA[17:0];
		end
	end

	// Set wins over clear on every sticky flag and fault state
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ao_st_r     <= SSD_FLT_IDLE;
			prev_mode_r <= SSD_MODE_HIZ;
			DRIVE_MODE  <= SSD_MODE_HIZ;
			ao_short_r  <= 1'b0;
			ao_ovld_r   <= 1'b0;
		end else begin
			ao_short_r <= AO_SHORT_DET || (ao_short_r && !ao_clr);
			ao_ovld_r  <= AO_OVLD_DET || (ao_ovld_r && !ao_clr);
			if (ao_trip) begin
				ao_st_r <= SSD_FLT_TRIP;
				if (ao_st_r == SSD_FLT_IDLE)
					prev_mode_r <= DRIVE_MODE;
			end else if (ao_clr)
				ao_st_r <= SSD_FLT_IDLE;
			if (do_restore)
				DRIVE_MODE <= prev_mode_r;
			else if (do_float)
				DRIVE_MODE <= SSD_MODE_HIZ;
			else if (wr_ctrl)
				DRIVE_MODE <= HWDATA[`SSD_CTRL_MODE_LO+1:`SSD_CTRL_MODE_LO];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sw_st_r    <= SSD_FLT_IDLE;
			sw_short_r <= 1'b0;
			sw_ovld_r  <= 1'b0;
			SW_LIMIT   <= 1'b0;
			SW_CLOSE   <= 1'b0;
		end else begin
			sw_short_r <= SW_SHORT_DET || (sw_short_r && !do_swexit);
			sw_ovld_r  <= SW_OVLD_DET || (sw_ovld_r && !do_swexit);
			if (sw_trip) begin
				sw_st_r  <= SSD_FLT_TRIP;
				SW_LIMIT <= 1'b1;
			end else if (do_swexit) begin
				sw_st_r  <= SSD_FLT_IDLE;
				SW_LIMIT <= 1'b0;
			end
			if (do_swexit)
				SW_CLOSE <= 1'b1;
			else if (wr_ctrl)
				SW_CLOSE <= HWDATA[`SSD_CTRL_CLOSE];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			WAVE_RUN  <= 1'b0;
			OUT_FAULT <= 1'b0;
			SW_FAULT  <= 1'b0;
			HRDATA    <= 32'h0;
		end else begin
			WAVE_RUN  <= do_start || (wave_run_r && !do_stop);
			OUT_FAULT <= ao_short_r || ao_ovld_r;
			SW_FAULT  <= sw_short_r || sw_ovld_r;
			HRDATA    <= (ahb_sel && !HWRITE) ? rd_mux : 32'h0;
		end
	end

	// ****************************************
	// Subsystem register access
	// ****************************************
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			REG_WR    <= 1'b0;
			REG_RD    <= 1'b0;
			REG_SUB   <= 2'b00;
			REG_ADDR  <= 8'h00;
			REG_WDATA <= 16'h0;
		end else begin
			REG_RD <= do_reg_rd;
			REG_WR <= wdata_valid_r;
			if (c_ok && c_reg) begin
				REG_SUB  <= c_sub;
				REG_ADDR <= c_code;
			end
			if (wdata_valid_r)
				REG_WDATA <= wdata_r;
		end
	end

	// ****************************************
	// Burst fetch and two-entry buffer
	// ****************************************
	// Buffer stall holds the fetch pointer, so a slow reader loses no result
	logic              burst_r, rd_pend_r;
	logic [3:0]        ptr_r;
	logic [WORD_W-1:0] buf_mem [BUF_DEPTH];
	logic [PTR_W-1:0]  wr_ptr_r, rd_ptr_r;
	logic [CNT_W-1:0]  buf_cnt_r;
	logic [OC_W-1:0]   out_cnt_r;
	logic [WORD_W-1:0] out_sh_r;
	wire  [3:0]        nxt      = ssd_next_ch(mask_r, ptr_r);
	wire               in_ready = buf_cnt_r != CNT_W'(BUF_DEPTH);
	wire               out_vld  = buf_cnt_r != '0;
	wire               push     = (rd_pend_r || (burst_r && nxt[3])) && in_ready;
	wire  [WORD_W-1:0] push_d   = rd_pend_r ? {REG_RDATA, {(WORD_W-16){1'b0}}} : result_r[nxt[2:0]];
	wire               pop      = sclk_fall && (phase_r == SSD_PH_RESP) && (out_cnt_r == '0) && out_vld;

	always_ff @(posedge CLK) begin
		if (!RST_N || frame_off) begin
			burst_r   <= 1'b0;
			ptr_r     <= 4'h0;
			rd_pend_r <= 1'b0;
		end else begin
			if (do_burst) begin
				burst_r <= 1'b1;
				ptr_r   <= 4'h0;
			end else if (burst_r && in_ready) begin
				if (nxt[3])
					ptr_r <= {1'b0, nxt[2:0]} + 4'h1;
				else
					burst_r <= 1'b0;
			end
			if (do_reg_rd)
				rd_pend_r <= 1'b1;
			else if (in_ready)
				rd_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N || frame_off) begin
			wr_ptr_r  <= '0;
			rd_ptr_r  <= '0;
			buf_cnt_r <= '0;
		end else begin
			if (push) begin
				buf_mem[wr_ptr_r] <= push_d;
				wr_ptr_r <= (wr_ptr_r == PTR_W'(BUF_DEPTH - 1)) ? '0 : wr_ptr_r + PTR_W'(1);
			end
			if (pop)
				rd_ptr_r <= (rd_ptr_r == PTR_W'(BUF_DEPTH - 1)) ? '0 : rd_ptr_r + PTR_W'(1);
			buf_cnt_r <= buf_cnt_r + CNT_W'(push) - CNT_W'(pop);
		end
	end

	// ****************************************
	// Response shifter, changes on falling SCLK
	// ****************************************
	always_ff @(posedge CLK) begin
		if (!RST_N || frame_off) begin
			MISO      <= 1'b0;
			MISO_OE   <= 1'b0;
			out_cnt_r <= '0;
			out_sh_r  <= '0;
		end else begin
			MISO_OE <= 1'b1;
			if (sclk_fall && (phase_r == SSD_PH_RESP)) begin
				out_cnt_r <= (out_cnt_r == OC_W'(WORD_W - 1)) ? '0 : out_cnt_r + OC_W'(1);
				if (out_cnt_r == '0) begin
					MISO     <= out_vld ? buf_mem[rd_ptr_r][WORD_W-1] : 1'b0;
					out_sh_r <= out_vld ? {buf_mem[rd_ptr_r][WORD_W-2:0], 1'b0} : '0;
				end else begin
					MISO     <= out_sh_r[WORD_W-1];
					out_sh_r <= {out_sh_r[WORD_W-2:0], 1'b0};
				end
			end
		end
	end

endmodule : ssd_decoder
`default_nettype wire

// *** testbench/ssd_decoder_properties.sv ***
// Concurrent checks on the ports of the system command decoder
`timescale 1ns/100ps
`default_nettype none

module ssd_decoder_checker
	import ssd_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        AO_SHORT_DET,
	input wire logic        SW_SHORT_DET,
	input wire logic        WAVE_RUN,
	input wire logic [17:0] DAC_CODE,
	input wire logic        DAC_LOAD,
	input wire logic        SLEW_RESET,
	input wire logic [1:0]  DRIVE_MODE,
	input wire logic        OUT_FAULT,
	input wire logic        SW_FAULT,
	input wire logic        SW_CLOSE,
	input wire logic        SW_LIMIT,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [7:0]  REG_ADDR
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	// ****************************************
	// Assertions
	// ****************************************
	slew_load_a: assert property (SLEW_RESET |-> DAC_LOAD)
		else $error("slew reset without dac refresh");
	midscale_code_a: assert property (SLEW_RESET |-> ##[0:1] (DAC_CODE == 18'h00000))
		else $error("dac code not mid-scale after clear");
	midscale_idle_a: assert property (SLEW_RESET |-> !$past(WAVE_RUN))
		else $error("clear accepted while waveform runs");
	out_event_a: assert property (AO_SHORT_DET |-> ##2 OUT_FAULT)
		else $error("output fault not flagged");
	// Restore refreshes the dac, float parks the mode, nothing else clears stickies
	out_abort_a: assert property ($fell(OUT_FAULT) |-> ($past(DAC_LOAD) || DRIVE_MODE == SSD_MODE_HIZ))
		else $error("output fault left without abort effect");
	sw_trip_a: assert property (SW_SHORT_DET |-> ##2 (SW_FAULT && SW_LIMIT))
		else $error("switch fault not tripped");
	sw_close_a: assert property ($fell(SW_LIMIT) |-> SW_CLOSE)
		else $error("limiter freed without closing switch");
	sw_clear_a: assert property ($fell(SW_LIMIT) |=> !SW_FAULT)
		else $error("switch stickies not cleared");
	reg_rd_addr_a: assert property (REG_RD |-> REG_ADDR >= 8'h20)
		else $error("register read below register range");
	reg_pulse_a: assert property (REG_WR |=> !REG_WR)
		else $error("register write pulse too long");

	cover property (SLEW_RESET);
	cover property ($fell(SW_LIMIT));
	cover property ($fell(OUT_FAULT) && DRIVE_MODE == SSD_MODE_HIZ);

endmodule : ssd_decoder_checker

bind ssd_decoder ssd_decoder_checker u_chk (.CLK(CLK), .RST_N(RST_N), .AO_SHORT_DET(AO_SHORT_DET),
	.SW_SHORT_DET(SW_SHORT_DET), .WAVE_RUN(WAVE_RUN), .DAC_CODE(DAC_CODE), .DAC_LOAD(DAC_LOAD),
	.SLEW_RESET(SLEW_RESET), .DRIVE_MODE(DRIVE_MODE), .OUT_FAULT(OUT_FAULT), .SW_FAULT(SW_FAULT),
	.SW_CLOSE(SW_CLOSE), .SW_LIMIT(SW_LIMIT), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR));

`default_nettype wire

// *** testbench/ssd_host_model.sv ***
// Host microcontroller model acting as SPI master
`timescale 1ns/100ps
`default_nettype none

module ssd_host_model (
	output var logic sclk,
	output var logic cs_n,
	output var logic mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// ****************************************
	// Frame transfer, mode 0, 80 ns link clock
	// ****************************************
	task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
		rx = 64'h0;
		#3;
		cs_n = 1'b0;
		#80;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = tx[i];
			#40;
			sclk = 1'b1;
			rx[i] = miso & miso_oe;
			#40;
			sclk = 1'b0;
		end
		#40;
		cs_n = 1'b1;
		// Released line must not keep the last bit
		mosi = ~mosi;
		#80;
	endtask : frame

endmodule : ssd_host_model

`default_nettype wire

// *** testbench/ssd_tb.sv ***
// Self-checking bench of the system command decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end

module testbench;
	logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        ao_short = 1'b0, ao_ovld = 1'b0, sw_short = 1'b0, sw_ovld = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic        hready, hresp, sclk, cs_n, mosi, miso, miso_oe, wave_run, dac_load, slew_reset;
	logic        out_fault, sw_fault, sw_close, sw_limit, reg_wr, reg_rd;
	logic [17:0] dac_code;
	logic [1:0]  drive_mode, reg_sub;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic [63:0] rx;
	int          fails = 0, cmp_count = 0, loads = 0, slews = 0, wrs = 0, rds = 0;
	// Subsystem answers only in the cycle of the read strobe, so a late sample reads zero
	wire  [15:0] reg_rdata = (reg_rd === 1'b1) ? 16'hc3a5 : 16'h0;

	ssd_decoder dut (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
		.SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .AO_SHORT_DET(ao_short),
		.AO_OVLD_DET(ao_ovld), .SW_SHORT_DET(sw_short), .SW_OVLD_DET(sw_ovld), .REG_RDATA(reg_rdata),
		.WAVE_RUN(wave_run), .DAC_CODE(dac_code), .DAC_LOAD(dac_load), .SLEW_RESET(slew_reset),
		.DRIVE_MODE(drive_mode), .OUT_FAULT(out_fault), .SW_FAULT(sw_fault), .SW_CLOSE(sw_close),
		.SW_LIMIT(sw_limit), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_SUB(reg_sub), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata));
	ssd_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

	always #4 clk = ~clk;

	// Pulses are counted, a pulse that stands one cycle is easy to miss
	always @(posedge clk) begin
		loads += (dac_load === 1'b1);
		slews += (slew_reset === 1'b1);
		wrs += (reg_wr === 1'b1);
		rds += (reg_rd === 1'b1);
	end

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : ahb

	task automatic spi(input logic [63:0] tx, input int n);
		u_host.frame(tx, n, rx);
		repeat (4) @(posedge clk);
	endtask : spi

	task automatic pulse_gap;
		repeat (5) @(posedge clk);
	endtask : pulse_gap

	function automatic logic [15:0] cmd(input logic r, input logic [1:0] s, input logic [1:0] c, input logic [7:0] k);
		return {1'b0, r, 1'b1, s, c, k, 1'b0};
	endfunction : cmd

	task automatic end_sim;
		if (fails == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		ahb(1'b1, 8'h80, 32'hffffffff);
		ahb(1'b0, 8'h80, 32'h0);
		`CHK(rd, 32'h0)
		`CHK(hresp, 1'b0)
		ahb(1'b1, 8'h00, 32'h105);
		ahb(1'b1, 8'h40, 32'habc123);
		ahb(1'b1, 8'h44, 32'h111111);
		ahb(1'b1, 8'h48, 32'h5a5a5a);
		ahb(1'b0, 8'h00, 32'h0);
		`CHK(rd, 32'h105)
		ahb(1'b0, 8'h48, 32'h0);
		`CHK(rd, 32'h5a5a5a)
		spi({cmd(1'b1, 2'b00, 2'b00, 8'h05), 48'h0}, 64);
		`CHK(rx[47:0], 48'habc1235a5a5a)
		spi(cmd(1'b0, 2'b11, 2'b00, 8'h01), 16);
		`CHK(wave_run, 1'b1)
		ahb(1'b1, 8'h08, 32'h12345);
		spi(cmd(1'b0, 2'b11, 2'b00, 8'h02), 16);
		`CHK(dac_code, 18'h12345)
		`CHK(slews, 0)
		spi(cmd(1'b0, 2'b11, 2'b01, 8'h00), 16);
		`CHK(wave_run, 1'b1)
		spi(cmd(1'b0, 2'b11, 2'b00, 8'h00), 16);
		`CHK(wave_run, 1'b0)
		spi(cmd(1'b0, 2'b11, 2'b00, 8'h02), 16);
		`CHK(dac_code, 18'h00000)
		`CHK(slews, 1)
		ahb(1'b1, 8'h08, 32'h2aaaa);
		spi(cmd(1'b0, 2'b11, 2'b00, 8'h07), 16);
		`CHK({wave_run, dac_code}, {1'b0, 18'h2aaaa})
		ahb(1'b0, 8'h08, 32'h0);
		`CHK(rd, 32'h2aaaa)
		spi(cmd(1'b0, 2'b11, 2'b00, 8'h03), 16);
		spi(cmd(1'b0, 2'b11, 2'b00, 8'h04), 16);
		`CHK(drive_mode, 2'b01)
		`CHK(loads, 3)
		ao_short <= 1'b1;
		@(posedge clk);
		ao_short <= 1'b0;
		pulse_gap();
		`CHK(out_fault, 1'b1)
		ahb(1'b1, 8'h00, 32'h205);
		spi(cmd(1'b0, 2'b11, 2'b00, 8'h03), 16);
		`CHK({out_fault, drive_mode}, 3'b001)
		`CHK(loads, 4)
		ao_ovld <= 1'b1;
		@(posedge clk);
		ao_ovld <= 1'b0;
		pulse_gap();
		spi(cmd(1'b0, 2'b11, 2'b00, 8'h04), 16);
		`CHK({out_fault, drive_mode}, 3'b000)
		spi(cmd(1'b0, 2'b11, 2'b00, 8'h05), 16);
		`CHK(sw_close, 1'b0)
		sw_short <= 1'b1;
		@(posedge clk);
		sw_short <= 1'b0;
		sw_ovld <= 1'b1;
		@(posedge clk);
		sw_ovld <= 1'b0;
		pulse_gap();
		`CHK({sw_fault, sw_limit}, 2'b11)
		ahb(1'b0, 8'h04, 32'h0);
		`CHK(rd, 32'ha0)
		spi(cmd(1'b0, 2'b11, 2'b00, 8'h05), 16);
		`CHK({sw_fault, sw_limit, sw_close}, 3'b001)
		spi({32'h0, cmd(1'b0, 2'b00, 2'b00, 8'h30), 16'hbeef}, 32);
		`CHK(wrs, 1)
		`CHK({reg_sub, reg_addr, reg_wdata}, 26'h030beef)
		spi({32'h0, cmd(1'b1, 2'b11, 2'b00, 8'h41), 16'h0}, 32);
		`CHK({reg_sub, reg_addr, rx[15:0]}, 26'h341c3a5)
		`CHK(rds, 1)
		end_sim();
	end

	// Whole run needs well under a fifth of this span
	initial begin
		#300000;
		fails++;
		end_sim();
	end

endmodule : testbench

`default_nettype wire
